// *** src/port_cfg_cfg.svh ***
`ifndef PORT_CFG_CFG_SVH
`define PORT_CFG_CFG_SVH

// Register indices within a port block; byte address is four times
// ((port << 12) | index)
`define IFC_A_IDX 12'h300
`define IFC_B_IDX 12'h301
`define MAC_A_IDX 12'h400
`define MAC_B_IDX 12'h401

// Interface control A fields
`define IFC_A_DUPLEX_BIT 6
`define IFC_A_TXFC_BIT   5
`define IFC_A_LOWSPD_BIT 4
`define IFC_A_RXFC_BIT   3
`define IFC_A_WMASK      8'h7F
`define IFC_A_RESET      8'h50

// Interface control B fields
`define IFC_B_GIGOFF_BIT 6
`define IFC_B_INGDLY_BIT 4
`define IFC_B_EGRDLY_BIT 3
`define IFC_B_ROLE_BIT   2
`define IFC_B_TYPE_LSB   0
`define IFC_B_WMASK      8'hFF
`define IFC_B_RESET      8'h08

// MAC control A and B fields
`define MAC_A_STORM_BIT  1
`define MAC_A_WMASK      8'h0B
`define MAC_A_RESET      8'h00
`define MAC_B_BP_BIT     3
`define MAC_B_PASS_BIT   0
`define MAC_B_WMASK      8'hBF
`define MAC_B_RESET      8'h00

`endif

// *** src/port_cfg_pkg.sv ***
`default_nettype none
package port_cfg_pkg;
  // Port line speed as seen by the datapath
  typedef enum logic [1:0] {SPEED_10, SPEED_100, SPEED_1000} link_speed_e;
  // External interface kind
  typedef enum logic [1:0] {IF_RGMII, IF_RMII, IF_MII} iface_kind_e;
  // Register targeted by a bus transfer
  typedef enum logic [2:0] {SEL_NONE, SEL_IFC_A, SEL_IFC_B, SEL_MAC_A, SEL_MAC_B} reg_sel_e;
endpackage
`default_nettype wire

// *** src/port_xmii_mac_config.sv ***
// The implementer's own choice: the AHB-Lite interface to the registers.
`include "port_cfg_cfg.svh"
`default_nettype none
module port_xmii_mac_config #(
  parameter int NUM_PORTS   = 7,
  parameter int IFACE_FIRST = 6
) (
  input  wire logic                      MCLK,
  input  wire logic                      RESET_N,
  // AHB-Lite slave
  input  wire logic                      HSEL,
  input  wire logic [31:0]               HADDR,
  input  wire logic [1:0]                HTRANS,
  input  wire logic                      HWRITE,
  input  wire logic [2:0]                HSIZE,
  input  wire logic [31:0]               HWDATA,
  input  wire logic                      HREADY,
  output var  logic [31:0]               HRDATA,
  output var  logic                      HREADYOUT,
  output var  logic                      HRESP,
  // Configuration straps (asynchronous pins)
  input  wire logic                      FLOW_CONTROL_STRAP,
  input  wire logic                      PORT_A_GIGABIT_STRAP,
  input  wire logic                      PORT_B_GIGABIT_STRAP,
  input  wire logic                      PORT_A_CLOCK_ROLE_STRAP,
  input  wire logic                      PORT_B_CLOCK_ROLE_STRAP,
  input  wire logic [1:0]                PORT_A_IFACE_TYPE_STRAP,
  input  wire logic [1:0]                PORT_B_IFACE_TYPE_STRAP,
  // Duplex of internal ports from same-clock MAC logic, bit n-1 is port n
  input  wire logic [NUM_PORTS-1:0]      PORT_HALF_DUPLEX,
  // External interface settings, index 0 is port IFACE_FIRST
  output var  logic [1:0]                IFACE_FULL_DUPLEX,
  output var  logic [1:0]                IFACE_TX_PAUSE_EN,
  output var  logic [1:0]                IFACE_RX_PAUSE_EN,
  output var  port_cfg_pkg::link_speed_e IFACE_SPEED [2],
  output var  logic [1:0]                IFACE_INGRESS_DELAY_EN,
  output var  logic [1:0]                IFACE_EGRESS_DELAY_EN,
  output var  port_cfg_pkg::iface_kind_e IFACE_TYPE [2],
  output var  logic [1:0]                IFACE_MII_MAC_ROLE,
  output var  logic [1:0]                IFACE_MII_CLOCK_DRIVE,
  output var  logic [1:0]                IFACE_RMII_REDUCED_IFACE_REF_CLOCK_IN,
  output var  logic [1:0]                IFACE_RMII_REDUCED_IFACE_REF_CLOCK_GEN,
  // Switch MAC settings, bit n-1 is port n
  output var  logic [NUM_PORTS-1:0]      STORM_PROTECT_EN,
  output var  logic [NUM_PORTS-1:0]      BACKPRESSURE_ACTIVE,
  output var  logic [NUM_PORTS-1:0]      BAD_FRAME_MIRROR_FWD
);
  import port_cfg_pkg::*;

  localparam int IFACE_PORTS = 2;

  // Overview of this block:
  // Two groups of byte-wide registers sit behind one word-wide bus slave.
  // The interface control pair exists only for the two external ports,
  // which are the last two switch ports.
  // The MAC control pair is repeated for every switch port.
  // Each register takes the low byte of one aligned bus word.
  // Every setting leaves through a flop, so the datapath never sees
  // a glitch while the bus is part way through a transfer.
  // The price is one cycle of latency between the write and its effect.
  // That cost is harmless, because software only changes these settings
  // while the link is idle.

  // Masked write: only writable bits take the bus value
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // Two-bit type code to interface kind; both upper codes mean MII
  function automatic iface_kind_e kind_of(input logic [1:0] code);
    kind_of = (code == 2'b00) ? IF_RGMII : (code == 2'b01) ? IF_RMII : IF_MII;
  endfunction

  // Strap handling:
  // Strap pins are board levels with no relation to the system clock.
  // They are meant to be static, but nothing guarantees that they are
  // settled at the instant of our clock edge.
  // Two flops per pin keep metastability away from the reset values.
  // Reset must stay low for at least three edges so that the second
  // stage holds a good level before the registers take it.
  // Strap synchronisers; the first stage feeds only the second
  logic [7:0] strap_meta_reg;            // First stage
  logic [7:0] strap_sync_reg;            // Safe to read
  wire  [7:0] strap_raw = {FLOW_CONTROL_STRAP, PORT_A_GIGABIT_STRAP, PORT_B_GIGABIT_STRAP,
                           PORT_A_CLOCK_ROLE_STRAP, PORT_B_CLOCK_ROLE_STRAP,
                           1'b0, 1'b0, 1'b0};
  logic [3:0] type_meta_reg;             // First stage, both type straps
  logic [3:0] type_sync_reg;             // Safe to read

  // Straps run freely so they are settled while reset is still held
  always_ff @(posedge MCLK) begin
    strap_meta_reg <= strap_raw;
    strap_sync_reg <= strap_meta_reg;
    type_meta_reg  <= {PORT_A_IFACE_TYPE_STRAP, PORT_B_IFACE_TYPE_STRAP};
    type_sync_reg  <= type_meta_reg;
  end

  // Strap-derived reset values per interface port
  wire       fc_strap = strap_sync_reg[7];
  wire [1:0] gig_strap  = {strap_sync_reg[5], strap_sync_reg[6]};
  wire [1:0] role_strap = {strap_sync_reg[3], strap_sync_reg[4]};
  wire [7:0] ifc_a_rst = `IFC_A_RESET | (8'(fc_strap) << `IFC_A_TXFC_BIT)
                                     | (8'(fc_strap) << `IFC_A_RXFC_BIT);
  wire [7:0] ifc_b_rst [IFACE_PORTS];
  assign ifc_b_rst[0] = `IFC_B_RESET | (8'(gig_strap[0]) << `IFC_B_GIGOFF_BIT)
                        | (8'(role_strap[0]) << `IFC_B_ROLE_BIT) | 8'(type_sync_reg[3:2]);
  assign ifc_b_rst[1] = `IFC_B_RESET | (8'(gig_strap[1]) << `IFC_B_GIGOFF_BIT)
                        | (8'(role_strap[1]) << `IFC_B_ROLE_BIT) | 8'(type_sync_reg[1:0]);

  // Register storage
  logic [7:0] ifc_a_reg [IFACE_PORTS];   // Duplex, speed, flow enables
  logic [7:0] ifc_b_reg [IFACE_PORTS];   // Gigabit, delays, role, type
  logic [7:0] mac_a_reg [NUM_PORTS];     // Storm protection
  logic [7:0] mac_b_reg [NUM_PORTS];     // Back pressure, pass-all

  // Address map:
  // The byte address is four times the word index, and the word index
  // holds the port number above a twelve-bit register index.
  // Any address bit above the port field must be zero.
  // The two lowest address bits must be zero as well.
  // A miss anywhere selects nothing: a write is dropped, a read
  // returns zero, and the response is still OKAY.
  // The decode only looks at the address phase; the data phase works
  // from the latched selection alone.
  // Address phase decode
  wire [14:0] idx      = HADDR[16:2];
  wire [2:0]  a_port   = idx[14:12];
  wire [11:0] a_off    = idx[11:0];
  wire        a_clean  = (HADDR[31:17] == 15'h0000) && (HADDR[1:0] == 2'b00);
  wire        a_is_mac = (int'(a_port) >= 1) && (int'(a_port) <= NUM_PORTS);
  wire        a_is_ifc = (int'(a_port) >= IFACE_FIRST) && (int'(a_port) < IFACE_FIRST + IFACE_PORTS);
  wire [2:0]  ifc_slot = 3'(int'(a_port) - IFACE_FIRST);
  wire [2:0]  mac_slot = a_port - 3'h1;
  wire        a_take   = HSEL && HTRANS[1] && HREADY;
  reg_sel_e   a_sel;
  assign a_sel = !a_clean                          ? SEL_NONE  :
                 (a_off == `IFC_A_IDX && a_is_ifc) ? SEL_IFC_A :
                 (a_off == `IFC_B_IDX && a_is_ifc) ? SEL_IFC_B :
                 (a_off == `MAC_A_IDX && a_is_mac) ? SEL_MAC_A :
                 (a_off == `MAC_B_IDX && a_is_mac) ? SEL_MAC_B : SEL_NONE;
  wire [2:0]  a_slot = (a_sel == SEL_IFC_A || a_sel == SEL_IFC_B) ? ifc_slot : mac_slot;

  // Data phase state
  reg_sel_e   sel_reg;                   // Register of the pending transfer
  logic [2:0] slot_reg;                  // Port slot of the pending transfer
  logic       wr_pend_reg;               // Write data phase this cycle
  logic       rd_pend_reg;               // Read waiting for its data

  // Data phase tracking:
  // A write lands on the edge that closes its data phase, using the
  // bus data that stands during that phase.
  // A read is captured one cycle later. Adding that wait state keeps
  // the read path free of any forwarding logic.
  // The trade is one extra cycle on every read.
  // Latch the address phase; reads get one wait state so that data
  // written just before is visible without a bypass path
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      sel_reg     <= SEL_NONE;
      slot_reg    <= 3'h0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
    end else if (a_take) begin
      sel_reg     <= a_sel;
      slot_reg    <= a_slot;
      wr_pend_reg <= HWRITE;
      rd_pend_reg <= !HWRITE;
    end else begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
    end
  end

  // Read selection; unmapped addresses and read-only bits read zero
  wire [7:0] rd_byte = (sel_reg == SEL_IFC_A) ? (ifc_a_reg[slot_reg[0]] & `IFC_A_WMASK) :
                       (sel_reg == SEL_IFC_B) ? ifc_b_reg[slot_reg[0]] :
                       (sel_reg == SEL_MAC_A) ? (mac_a_reg[slot_reg] & `MAC_A_WMASK) :
                       (sel_reg == SEL_MAC_B) ? (mac_b_reg[slot_reg] & `MAC_B_WMASK) : 8'h00;

  // Ready drops only for the one cycle after a read is taken.
  // A write never stalls the bus.
  // Read data holds until the next read completes, so a late sampler
  // still sees the right value.
  // Bus answer: writes without wait, reads after one wait cycle; always OKAY
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h0000_0000;
    end else begin
      HREADYOUT <= !(a_take && !HWRITE);
      HRESP     <= 1'b0;
      if (rd_pend_reg) begin
        HRDATA <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Register update rules:
  // Only bits in the writable mask take the bus value.
  // Read-only bits keep their reset level for good.
  // Reserved bits that are writable are stored and read back as written.
  // Interface port registers; reset values partly from straps
  always_ff @(posedge MCLK) begin
    for (int i = 0; i < IFACE_PORTS; i++) begin
      if (!RESET_N) begin
        ifc_a_reg[i] <= ifc_a_rst;
        ifc_b_reg[i] <= ifc_b_rst[i];
      end else if (wr_pend_reg && slot_reg == 3'(i)) begin
        if (sel_reg == SEL_IFC_A) begin
          ifc_a_reg[i] <= merge(ifc_a_reg[i], HWDATA[7:0], `IFC_A_WMASK);
        end
        if (sel_reg == SEL_IFC_B) begin
          ifc_b_reg[i] <= merge(ifc_b_reg[i], HWDATA[7:0], `IFC_B_WMASK);
        end
      end
    end
  end

  // Slot n-1 belongs to switch port n.
  // Port zero has no MAC registers, so its addresses decode to nothing.
  // Per-port MAC registers, replicated for every switch port
  always_ff @(posedge MCLK) begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (!RESET_N) begin
        mac_a_reg[i] <= `MAC_A_RESET;
        mac_b_reg[i] <= `MAC_B_RESET;
      end else if (wr_pend_reg && slot_reg == 3'(i)) begin
        if (sel_reg == SEL_MAC_A) begin
          mac_a_reg[i] <= merge(mac_a_reg[i], HWDATA[7:0], `MAC_A_WMASK);
        end
        if (sel_reg == SEL_MAC_B) begin
          mac_b_reg[i] <= merge(mac_b_reg[i], HWDATA[7:0], `MAC_B_WMASK);
        end
      end
    end
  end

  // Interface settings decoded from the registers.
  // The clock-role bit means different things for MII and RMII, and nothing for RGMII.
  // It is split into one output per meaning, so the pad logic never has
  // to decode the kind again itself.
  logic [1:0]  fd_next;                  // Full duplex
  logic [1:0]  txp_next;                 // Transmit pause allowed
  logic [1:0]  rxp_next;                 // Receive pause allowed
  logic [1:0]  ing_next;                 // Ingress clock delay
  logic [1:0]  egr_next;                 // Egress clock delay
  logic [1:0]  mac_role_next;            // MII, clocks come in
  logic [1:0]  mii_drv_next;             // MII, clocks go out
  logic [1:0]  rmii_in_next;             // Reduced, reference comes in
  logic [1:0]  rmii_gen_next;            // Reduced, reference made here
  link_speed_e speed_next [IFACE_PORTS];
  iface_kind_e kind_next  [IFACE_PORTS];
  logic [NUM_PORTS-1:0] half_dup;        // Effective half duplex per port

  for (genvar g = 0; g < IFACE_PORTS; g++) begin : g_ifc
    wire role = ifc_b_reg[g][`IFC_B_ROLE_BIT];
    assign fd_next[g]  = ifc_a_reg[g][`IFC_A_DUPLEX_BIT];
    // Pause flow control only applies in full duplex
    assign txp_next[g] = fd_next[g] && ifc_a_reg[g][`IFC_A_TXFC_BIT];
    assign rxp_next[g] = fd_next[g] && ifc_a_reg[g][`IFC_A_RXFC_BIT];
    // Low-speed bit only matters when gigabit is deselected
    assign speed_next[g] = !ifc_b_reg[g][`IFC_B_GIGOFF_BIT] ? SPEED_1000 :
                           ifc_a_reg[g][`IFC_A_LOWSPD_BIT] ? SPEED_100 : SPEED_10;
    assign ing_next[g]  = ifc_b_reg[g][`IFC_B_INGDLY_BIT];
    assign egr_next[g]  = ifc_b_reg[g][`IFC_B_EGRDLY_BIT];
    assign kind_next[g] = kind_of(ifc_b_reg[g][`IFC_B_TYPE_LSB +: 2]);
    assign mac_role_next[g] = (kind_next[g] == IF_MII) && role;
    assign mii_drv_next[g]  = (kind_next[g] == IF_MII) && !role;
    assign rmii_in_next[g]  = (kind_next[g] == IF_RMII) && role;
    assign rmii_gen_next[g] = (kind_next[g] == IF_RMII) && !role;
  end

  // Duplex source per port:
  // The external ports have a duplex bit of their own.
  // The inner ports learn their duplex from their own MAC logic, which
  // runs on this same clock, so no synchroniser is needed there.
  // Back pressure is gated by this effective duplex.
  // Interface ports take duplex from their register, others from the MAC
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_dup
    if (p + 1 >= IFACE_FIRST && p + 1 < IFACE_FIRST + IFACE_PORTS) begin : g_x
      assign half_dup[p] = !fd_next[p + 1 - IFACE_FIRST];
    end else begin : g_i
      assign half_dup[p] = PORT_HALF_DUPLEX[p];
    end
  end

  // Per-port MAC settings
  logic [NUM_PORTS-1:0] storm_next, bp_next, pass_next;
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_mac
    assign storm_next[p] = mac_a_reg[p][`MAC_A_STORM_BIT];
    assign bp_next[p]    = mac_b_reg[p][`MAC_B_BP_BIT] && half_dup[p];
    // Zero drops bad frames, one forwards them to mirror ports only;
    // flow control frame filtering is not touched here
    assign pass_next[p]  = mac_b_reg[p][`MAC_B_PASS_BIT];
  end

  // Output stage:
  // While reset is held, the outputs show fixed safe levels: full duplex,
  // gigabit speed, the first interface kind, egress delay on and all
  // optional features off.
  // The strap-based values only appear from the first edge after release.
  // A consumer that acts during reset must therefore not rely on the
  // strapped kind.
  // Output flops: settings reach the datapath one cycle after the write
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      IFACE_FULL_DUPLEX      <= 2'b11;
      IFACE_TX_PAUSE_EN      <= 2'b00;
      IFACE_RX_PAUSE_EN      <= 2'b00;
      IFACE_INGRESS_DELAY_EN <= 2'b00;
      IFACE_EGRESS_DELAY_EN  <= 2'b11;
      IFACE_MII_MAC_ROLE     <= 2'b00;
      IFACE_MII_CLOCK_DRIVE  <= 2'b00;
      IFACE_RMII_REDUCED_IFACE_REF_CLOCK_IN   <= 2'b00;
      IFACE_RMII_REDUCED_IFACE_REF_CLOCK_GEN  <= 2'b00;
      STORM_PROTECT_EN       <= '0;
      BACKPRESSURE_ACTIVE    <= '0;
      BAD_FRAME_MIRROR_FWD   <= '0;
      for (int i = 0; i < IFACE_PORTS; i++) begin
        IFACE_SPEED[i] <= SPEED_1000;
        IFACE_TYPE[i]  <= IF_RGMII;
      end
    end else begin
      IFACE_FULL_DUPLEX      <= fd_next;
      IFACE_TX_PAUSE_EN      <= txp_next;
      IFACE_RX_PAUSE_EN      <= rxp_next;
      IFACE_INGRESS_DELAY_EN <= ing_next;
      IFACE_EGRESS_DELAY_EN  <= egr_next;
      IFACE_MII_MAC_ROLE     <= mac_role_next;
      IFACE_MII_CLOCK_DRIVE  <= mii_drv_next;
      IFACE_RMII_REDUCED_IFACE_REF_CLOCK_IN   <= rmii_in_next;
      IFACE_RMII_REDUCED_IFACE_REF_CLOCK_GEN  <= rmii_gen_next;
      STORM_PROTECT_EN       <= storm_next;
      BACKPRESSURE_ACTIVE    <= bp_next;
      BAD_FRAME_MIRROR_FWD   <= pass_next;
      for (int i = 0; i < IFACE_PORTS; i++) begin
        IFACE_SPEED[i] <= speed_next[i];
        IFACE_TYPE[i]  <= kind_next[i];
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/port_xmii_mac_config_monitor.sv ***
`default_nettype none
module port_xmii_mac_config_monitor #(
  parameter int NUM_PORTS = 7
) (
  input wire logic                      MCLK,
  input wire logic                      RESET_N,
  input wire logic                      HSEL,
  input wire logic [1:0]                HTRANS,
  input wire logic                      HWRITE,
  input wire logic                      HREADY,
  input wire logic [31:0]               HRDATA,
  input wire logic                      HREADYOUT,
  input wire logic [1:0]                IFACE_FULL_DUPLEX,
  input wire logic [1:0]                IFACE_TX_PAUSE_EN,
  input wire logic [1:0]                IFACE_RX_PAUSE_EN,
  input wire logic [1:0]                IFACE_INGRESS_DELAY_EN,
  input wire logic [1:0]                IFACE_EGRESS_DELAY_EN,
  input var  port_cfg_pkg::iface_kind_e IFACE_TYPE [2],
  input wire logic [1:0]                IFACE_MII_MAC_ROLE,
  input wire logic [1:0]                IFACE_MII_CLOCK_DRIVE,
  input wire logic [1:0]                IFACE_RMII_REDUCED_IFACE_REF_CLOCK_IN,
  input wire logic [1:0]                IFACE_RMII_REDUCED_IFACE_REF_CLOCK_GEN,
  input wire logic [NUM_PORTS-1:0]      STORM_PROTECT_EN,
  input wire logic [NUM_PORTS-1:0]      BACKPRESSURE_ACTIVE
);
  import port_cfg_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  // Transfer accepted at this edge
  wire logic take = HSEL && HTRANS[1] && HREADY;
  chk_rd_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read did not take one wait state");
  chk_wr_nowait: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write was stalled");
  chk_rdata_high: assert property (HREADYOUT |-> HRDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // Read data must not move while a read waits
  chk_rdata_hold: assert property (!HREADYOUT |-> HRDATA == $past(HRDATA))
    else $error("read data moved during wait");
  chk_tx_pause_fd: assert property ((IFACE_TX_PAUSE_EN & ~IFACE_FULL_DUPLEX) == 2'h0)
    else $error("transmit pause in half duplex");
  chk_rx_pause_fd: assert property ((IFACE_RX_PAUSE_EN & ~IFACE_FULL_DUPLEX) == 2'h0)
    else $error("receive pause in half duplex");
  chk_bp_half: assert property ((BACKPRESSURE_ACTIVE[NUM_PORTS-1 -: 2] & IFACE_FULL_DUPLEX) == 2'h0)
    else $error("back pressure in full duplex");
  chk_mii_role: assert property (((IFACE_TYPE[0] == IF_MII) == (IFACE_MII_MAC_ROLE[0] | IFACE_MII_CLOCK_DRIVE[0]))
    && ((IFACE_TYPE[1] == IF_MII) == (IFACE_MII_MAC_ROLE[1] | IFACE_MII_CLOCK_DRIVE[1]))
    && !(|(IFACE_MII_MAC_ROLE & IFACE_MII_CLOCK_DRIVE)))
    else $error("clock role wrong in MII mode");
  chk_rmii_clk: assert property (((IFACE_TYPE[0] == IF_RMII) == (IFACE_RMII_REDUCED_IFACE_REF_CLOCK_IN[0] | IFACE_RMII_REDUCED_IFACE_REF_CLOCK_GEN[0]))
    && ((IFACE_TYPE[1] == IF_RMII) == (IFACE_RMII_REDUCED_IFACE_REF_CLOCK_IN[1] | IFACE_RMII_REDUCED_IFACE_REF_CLOCK_GEN[1]))
    && !(|(IFACE_RMII_REDUCED_IFACE_REF_CLOCK_IN & IFACE_RMII_REDUCED_IFACE_REF_CLOCK_GEN)))
    else $error("reference clock role wrong in RMII mode");
  chk_reset_out: assert property ($rose(RESET_N) |-> IFACE_FULL_DUPLEX == 2'h3 && IFACE_EGRESS_DELAY_EN == 2'h3
    && IFACE_INGRESS_DELAY_EN == 2'h0 && STORM_PROTECT_EN == '0)
    else $error("outputs wrong after reset");
  cov_read: cover property (take && !HWRITE);
  cov_bp: cover property (BACKPRESSURE_ACTIVE != '0);
  cov_refgen: cover property (IFACE_RMII_REDUCED_IFACE_REF_CLOCK_GEN != 2'h0);
endmodule
bind port_xmii_mac_config port_xmii_mac_config_monitor #(.NUM_PORTS(NUM_PORTS)) mon_u (.*);
`default_nettype wire

// *** tb/port_xmii_mac_config_tb_top.sv ***
`include "port_cfg_cfg.svh"
`default_nettype none
module port_xmii_mac_config_tb_top;
  import port_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK, RESET_N, HSEL, HWRITE, HREADYOUT, HRESP, rd_ph;
  logic [31:0] HADDR, HWDATA, HRDATA, rs;
  logic [1:0] HTRANS, PORT_A_IFACE_TYPE_STRAP, PORT_B_IFACE_TYPE_STRAP;
  logic [2:0] HSIZE;
  logic FLOW_CONTROL_STRAP, PORT_A_GIGABIT_STRAP, PORT_B_GIGABIT_STRAP;
  logic PORT_A_CLOCK_ROLE_STRAP, PORT_B_CLOCK_ROLE_STRAP;
  logic [6:0] PORT_HALF_DUPLEX, STORM_PROTECT_EN, BACKPRESSURE_ACTIVE, BAD_FRAME_MIRROR_FWD;
  logic [1:0] IFACE_FULL_DUPLEX, IFACE_TX_PAUSE_EN, IFACE_RX_PAUSE_EN, IFACE_INGRESS_DELAY_EN;
  logic [1:0] IFACE_EGRESS_DELAY_EN, IFACE_MII_MAC_ROLE, IFACE_MII_CLOCK_DRIVE;
  logic [1:0] IFACE_RMII_REDUCED_IFACE_REF_CLOCK_IN, IFACE_RMII_REDUCED_IFACE_REF_CLOCK_GEN;
  link_speed_e IFACE_SPEED [2];
  iface_kind_e IFACE_TYPE [2];
  wire logic HREADY = HREADYOUT; // Single slave drives the bus ready
  logic [7:0] ia [2], ib [2], ma [7], mb [7]; // Shadow register values
  logic [31:0] exp_q [$]; // Expected read data, oldest first
  int fail_count, checked;
  port_xmii_mac_config dut_u (.*);
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  // Xorshift source with a fixed seed
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait for an edge with ready high
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      final_report();
    end
  endtask
  // One single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    wt();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rd_ph <= !w;
    wt();
    rd_ph <= 1'b0;
  endtask
  // Read results are compared as they appear
  always @(posedge MCLK) if (rd_ph && HREADYOUT === 1'b1) check(HRDATA, exp_q.pop_front());
  function automatic logic [31:0] ad(input int p, input logic [11:0] x);
    return ((p << 12) | x) << 2;
  endfunction
  // Unmapped places read zero
  function automatic logic [31:0] ex(input int p, input logic [11:0] x);
    if (p > 5 && x == `IFC_A_IDX) return ia[p-6];
    if (p > 5 && x == `IFC_B_IDX) return ib[p-6];
    if (p > 0 && x == `MAC_A_IDX) return ma[p-1];
    if (p > 0 && x == `MAC_B_IDX) return mb[p-1];
    return 32'h0;
  endfunction
  task automatic get(input int p, input logic [11:0] x);
    exp_q.push_back(ex(p, x));
    bus(1'b0, ad(p, x), 32'h0);
  endtask
  // Write, then keep only writable bits in the shadow
  task automatic put(input int p, input logic [11:0] x, input logic [7:0] v);
    bus(1'b1, ad(p, x), {rs[31:8], v});
    if (p > 5 && x == `IFC_A_IDX) ia[p-6] = v & `IFC_A_WMASK;
    if (p > 5 && x == `IFC_B_IDX) ib[p-6] = v & `IFC_B_WMASK;
    if (p > 0 && x == `MAC_A_IDX) ma[p-1] = v & `MAC_A_WMASK;
    if (p > 0 && x == `MAC_B_IDX) mb[p-1] = v & `MAC_B_WMASK;
  endtask
  task automatic get_all();
    for (int p = 1; p < 8; p++) begin
      get(p, `IFC_A_IDX);
      get(p, `IFC_B_IDX);
      get(p, `MAC_A_IDX);
      get(p, `MAC_B_IDX);
    end
  endtask
  task automatic chk_out();
    logic [7:0] a, b;
    logic h;
    for (int i = 0; i < 2; i++) begin
      a = ia[i];
      b = ib[i];
      check(IFACE_FULL_DUPLEX[i], a[6]);
      check(IFACE_TX_PAUSE_EN[i], a[5] & a[6]);
      check(IFACE_RX_PAUSE_EN[i], a[3] & a[6]);
      check(IFACE_SPEED[i], b[6] ? (a[4] ? SPEED_100 : SPEED_10) : SPEED_1000);
      check(IFACE_INGRESS_DELAY_EN[i], b[4]);
      check(IFACE_EGRESS_DELAY_EN[i], b[3]);
      check(IFACE_TYPE[i], b[1] ? IF_MII : (b[0] ? IF_RMII : IF_RGMII));
      check({IFACE_MII_MAC_ROLE[i], IFACE_MII_CLOCK_DRIVE[i]}, b[1] ? {b[2], !b[2]} : 2'h0);
      check({IFACE_RMII_REDUCED_IFACE_REF_CLOCK_IN[i], IFACE_RMII_REDUCED_IFACE_REF_CLOCK_GEN[i]}, b[1:0] == 2'h1 ? {b[2], !b[2]} : 2'h0);
    end
    for (int j = 0; j < 7; j++) begin
      h = (j < 5) ? PORT_HALF_DUPLEX[j] : !ia[j%5][6];
      check(STORM_PROTECT_EN[j], ma[j][1]);
      check(BACKPRESSURE_ACTIVE[j], mb[j][3] & h);
      check(BAD_FRAME_MIRROR_FWD[j], mb[j][0]);
    end
  endtask
  initial begin
    rs = 32'h000162D3;
    {HSEL, HWRITE, rd_ph, HADDR, HWDATA, HTRANS, RESET_N} = '0;
    HSIZE = 3'h2;
    {FLOW_CONTROL_STRAP, PORT_A_GIGABIT_STRAP, PORT_B_GIGABIT_STRAP, PORT_A_CLOCK_ROLE_STRAP,
     PORT_B_CLOCK_ROLE_STRAP, PORT_A_IFACE_TYPE_STRAP, PORT_B_IFACE_TYPE_STRAP} = rnd();
    PORT_HALF_DUPLEX = rnd();
    // Straps are stable before reset; shadow takes their reset effect
    ia[0] = `IFC_A_RESET | (FLOW_CONTROL_STRAP << 5) | (FLOW_CONTROL_STRAP << 3);
    ia[1] = ia[0];
    ib[0] = `IFC_B_RESET | (PORT_A_GIGABIT_STRAP << 6) | (PORT_A_CLOCK_ROLE_STRAP << 2) | PORT_A_IFACE_TYPE_STRAP;
    ib[1] = `IFC_B_RESET | (PORT_B_GIGABIT_STRAP << 6) | (PORT_B_CLOCK_ROLE_STRAP << 2) | PORT_B_IFACE_TYPE_STRAP;
    for (int j = 0; j < 7; j++) {ma[j], mb[j]} = {`MAC_A_RESET, `MAC_B_RESET};
    repeat (5) @(posedge MCLK);
    RESET_N <= 1'b1;
    get_all();
    #1;
    chk_out();
    // Every type code on each port, the rest random
    for (int k = 0; k < 16; k++) begin
      PORT_HALF_DUPLEX <= rnd();
      for (int p = 1; p < 8; p++) begin
        put(p, `MAC_A_IDX, rnd());
        put(p, `MAC_B_IDX, rnd());
      end
      put(6, `IFC_A_IDX, rnd());
      put(7, `IFC_A_IDX, rnd());
      put(6, `IFC_B_IDX, {rnd() >> 2, k[1:0]});
      put(7, `IFC_B_IDX, {rnd() >> 2, ~k[1:0]});
      @(posedge MCLK);
      #1;
      chk_out();
      @(posedge MCLK);
      get_all();
    end
    // Misaligned, out of range and unmapped places are refused
    put(7, 12'h302, 8'hFF);
    get(7, 12'h302);
    get(0, `MAC_A_IDX);
    exp_q.push_back(32'h0);
    bus(1'b0, ad(6, `IFC_A_IDX) | 32'h1, 32'h0);
    exp_q.push_back(32'h0);
    bus(1'b0, ad(6, `IFC_A_IDX) | 32'h20000, 32'h0);
    check(HRESP, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
